// ---- hdl/arq_pkg.sv ----
// constants shared by the output requantizer and resolution monitor
package arq_pkg;
  localparam int ARQ_DW = 14;
  localparam int ARQ_REQ_BITS = 9;
  localparam logic [3:0] ARQ_FULL_BITS = 4'he;
  localparam logic [3:0] ARQ_MIN_BITS = 4'h9;
  localparam logic [3:0] ARQ_HEAVY_BITS = 4'hc;
  // register offsets
  localparam logic [11:0] ARQ_REG_HB_CTRL = 12'h41e;
  localparam logic [11:0] ARQ_REG_REQ_PROFILE = 12'h420;
  localparam logic [11:0] ARQ_REG_REQ_TUNE = 12'h422;
  localparam logic [11:0] ARQ_REG_VRM_MODE = 12'h430;
  localparam logic [11:0] ARQ_REG_VRM_CENTER = 12'h434;
  localparam logic [11:0] ARQ_REG_VRM_STATUS = 12'h436;
  localparam logic [11:0] ARQ_REG_STAT_ROUTE = 12'h559;
  // field positions
  localparam int ARQ_HB_EN_BIT = 0;
  localparam int ARQ_HB_HP_BIT = 7;
  localparam int ARQ_REQ_EN_BIT = 3;
  localparam int ARQ_VRM_CPLX_BIT = 0;
  localparam int ARQ_VRM_WIDE_BIT = 1;
  localparam int ARQ_VRM_EN_BIT = 3;
  // reset values; requantizer comes up enabled in the narrow profile
  localparam logic [7:0] ARQ_HB_CTRL_RST = 8'h00;
  localparam logic [7:0] ARQ_REQ_PROFILE_RST = 8'h08;
  localparam logic [7:0] ARQ_REQ_TUNE_RST = 8'h00;
  localparam logic [7:0] ARQ_VRM_MODE_RST = 8'h00;
  localparam logic [7:0] ARQ_VRM_CENTER_RST = 8'h04;
  localparam logic [7:0] ARQ_STAT_ROUTE_RST = 8'h00;
  // requantizer profiles, band offsets in steps of 0.005 fs
  localparam logic [2:0] ARQ_PROFILE_NARROW = 3'h0;
  localparam logic [2:0] ARQ_PROFILE_WIDE = 3'h1;
  localparam logic [5:0] ARQ_TW_MAX_NARROW = 6'h3a;
  localparam logic [5:0] ARQ_TW_MAX_WIDE = 6'h2b;
  localparam logic [6:0] ARQ_CTR_OFS_NARROW = 7'h15;
  localparam logic [6:0] ARQ_CTR_OFS_WIDE = 7'h1c;
  localparam logic [6:0] ARQ_QUARTER_FS = 7'h32;
  localparam logic signed [15:0] ARQ_ATT_MUL = 16'sh16a7;
  localparam int ARQ_ATT_SHIFT = 13;
  // half-band weights for the even taps 0,2,4,6,8 (mirrored) and the centre tap
  localparam int ARQ_HB_TAPS = 19;
  localparam logic signed [11:0] ARQ_HB_COEF [0:4] = '{12'sh019, -12'sh02f, 12'sh05d,
    -12'sh0c2, 12'sh284};
  localparam logic signed [12:0] ARQ_HB_CENTER = 13'sh0400;
  localparam int ARQ_HB_SHIFT = 11;
  // monitor thresholds in lsb of a 14-bit word: -30,-24,-18,-12,-6 dBFS
  localparam logic [13:0] ARQ_VRM_THR [0:4] = '{14'h0103, 14'h0205, 14'h0407, 14'h080a,
    14'h100a};
  localparam int ARQ_PEAK_DECAY = 6;
  localparam logic [3:0] ARQ_REAL_CTR_MIN = 4'h2;
  localparam logic [3:0] ARQ_REAL_CTR_MAX = 4'h6;
  typedef enum logic [1:0] {
    ARQ_ROUTE_OFF,
    ARQ_ROUTE_HEAVY_OVR,
    ARQ_ROUTE_REDUCED_STATUS,
    ARQ_ROUTE_REDUCED_OVR
  } arq_route_t;
endpackage : arq_pkg

// ---- hdl/arq_skid.sv ----
// two-entry buffer between the monitor and the downstream receiver
`timescale 1ns/1ps
`default_nettype none
module arq_skid #(
  parameter int W = 14,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      // ready is registered from the next count so a stall never overruns
      in_ready_o <= (cnt_d < CW'(DEPTH));
      out_valid_o <= (cnt_d != '0);
    end
  end

  property p_no_overflow;
    @(posedge clk_i) disable iff (!rst_b_i)
    (cnt_q == CW'(DEPTH)) |-> !in_ready_o;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer accepts while full");

  c_full: cover property (@(posedge clk_i) disable iff (!rst_b_i) cnt_q == CW'(DEPTH));
endmodule : arq_skid
`default_nettype wire

// ---- hdl/arq_halfband.sv ----
// 19-tap half-band decimate-by-two filter, even taps plus centre only
`timescale 1ns/1ps
`default_nettype none
module arq_halfband
  import arq_pkg::*;
#(
  parameter int DW = ARQ_DW
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic adv_i,
  input wire logic valid_i,
  input wire logic signed [DW-1:0] data_i,
  input wire logic active_i,
  input wire logic hp_i,
  output logic valid_o,
  output logic signed [DW-1:0] data_o
);
  logic signed [DW-1:0] x_q [0:ARQ_HB_TAPS-2];
  logic signed [DW-1:0] tap [0:ARQ_HB_TAPS-1];
  logic phase_q;
  logic signed [31:0] acc;
  logic signed [31:0] rnd;
  logic signed [DW-1:0] sat;
  localparam logic signed [31:0] MAXV = 32'sd2 ** (DW - 1) - 32'sd1;
  localparam logic signed [31:0] MINV = -(32'sd2 ** (DW - 1));

  assign tap[0] = data_i;
  genvar g;
  generate
    for (g = 1; g < ARQ_HB_TAPS; g++) begin : g_tap
      assign tap[g] = x_q[g-1];
    end
  endgenerate

  always_comb begin
    // only the non-zero taps are summed; odd taps other than centre are zero
    acc = 32'(ARQ_HB_CENTER) * 32'(tap[9]);
    if (hp_i) begin
      acc = -acc;
    end
    for (int i = 0; i < 5; i++) begin
      acc = acc + 32'(ARQ_HB_COEF[i]) * (32'(tap[2*i]) + 32'(tap[18-2*i]));
    end
    rnd = (acc + (32'sd1 <<< (ARQ_HB_SHIFT - 1))) >>> ARQ_HB_SHIFT;
    if (rnd > MAXV) begin
      sat = MAXV[DW-1:0];
    end else if (rnd < MINV) begin
      sat = MINV[DW-1:0];
    end else begin
      sat = rnd[DW-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < ARQ_HB_TAPS - 1; i++) begin
        x_q[i] <= '0;
      end
    end else if (adv_i && valid_i) begin
      x_q[0] <= data_i;
      for (int i = 1; i < ARQ_HB_TAPS - 1; i++) begin
        x_q[i] <= x_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= 1'b0;
      valid_o <= 1'b0;
      data_o <= '0;
    end else if (adv_i) begin
      if (valid_i) begin
        phase_q <= active_i ? !phase_q : 1'b0;
      end
      // one output for every second accepted input when active, one per input otherwise
      valid_o <= valid_i && (!active_i || phase_q);
      data_o <= active_i ? sat : data_i;
    end
  end

  property p_decimate;
    @(posedge clk_i) disable iff (!rst_b_i)
    (adv_i && valid_i && active_i && !phase_q) |=> !valid_o;
  endproperty
  a_decimate: assert property (p_decimate) else $error("decimator emitted on even input");

  c_hp: cover property (@(posedge clk_i) disable iff (!rst_b_i) valid_o && active_i && hp_i);
endmodule : arq_halfband
`default_nettype wire

// ---- hdl/arq_top.sv ----
// per-channel requantizer, half-band decimator and resolution monitor
// How it works
// - symmetric 19-tap polyphase fixed decimator
// - fixed 12-bit tap weights as tabulated
// - odd taps except centre are zero
// - high-pass negates the centre tap only
// - low-pass passes up to half decimated rate
// - high-pass passes half to three halves rate
// - requantizer attenuates by 3.0 dB
// - per-channel requantizer enable and settings
// - requantizer enabled out of reset
// - mode 000 narrow profile, words 0..58
// - mode 001 wide profile, words 0..43
// - band edges from 0.005 fs tuning steps
// - keep up to 14 bits, never below 9
// - no gain loss, per-channel resolution monitor enable
// - complex 25/43 percent, real 25 percent
// - peak of out-of-mask level drives reduction
// - route one flag to status pins
// - reduced flag high whenever bits dropped
// - heavy flag high at 12 bits or fewer
// - drop one bit per 6 dB above -30 dBFS
// - mask centre from 4-bit field
// - centre steps of fs/16, real 2..6
// - half-band emits one per two inputs
// - half-band only with requantizer enabled
// - half-band mode from msb of control
`timescale 1ns/1ps
`default_nettype none
module arq_top
  import arq_pkg::*;
#(
  parameter int DW = ARQ_DW,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [DW-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output logic [DW-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic status_pin_o,
  output logic overrange_pin_pair_o
);
  localparam int DROP = DW - ARQ_REQ_BITS;

  // settings written over the serial port, one copy per channel instance
  logic [7:0] hb_ctrl_q;
  logic [7:0] requant_profile_select_q;
  logic [7:0] requant_band_tuning_q;
  logic [7:0] resolution_monitor_mode_q;
  logic [7:0] resolution_mask_center_q;
  logic [7:0] status_pin_routing_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hb_ctrl_q <= ARQ_HB_CTRL_RST;
      requant_profile_select_q <= ARQ_REQ_PROFILE_RST;
      requant_band_tuning_q <= ARQ_REQ_TUNE_RST;
      resolution_monitor_mode_q <= ARQ_VRM_MODE_RST;
      resolution_mask_center_q <= ARQ_VRM_CENTER_RST;
      status_pin_routing_q <= ARQ_STAT_ROUTE_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ARQ_REG_HB_CTRL) begin
        hb_ctrl_q <= reg_wdata_i;
      end else if (reg_addr_i == ARQ_REG_REQ_PROFILE) begin
        requant_profile_select_q <= reg_wdata_i;
      end else if (reg_addr_i == ARQ_REG_REQ_TUNE) begin
        requant_band_tuning_q <= reg_wdata_i;
      end else if (reg_addr_i == ARQ_REG_VRM_MODE) begin
        resolution_monitor_mode_q <= reg_wdata_i;
      end else if (reg_addr_i == ARQ_REG_VRM_CENTER) begin
        resolution_mask_center_q <= reg_wdata_i;
      end else if (reg_addr_i == ARQ_REG_STAT_ROUTE) begin
        status_pin_routing_q <= reg_wdata_i;
      end
    end
  end

  logic [3:0] bits_q;
  logic reduced_q;
  logic heavy_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ARQ_REG_HB_CTRL) begin
        reg_rdata_o <= hb_ctrl_q;
      end else if (reg_addr_i == ARQ_REG_REQ_PROFILE) begin
        reg_rdata_o <= requant_profile_select_q;
      end else if (reg_addr_i == ARQ_REG_REQ_TUNE) begin
        reg_rdata_o <= requant_band_tuning_q;
      end else if (reg_addr_i == ARQ_REG_VRM_MODE) begin
        reg_rdata_o <= resolution_monitor_mode_q;
      end else if (reg_addr_i == ARQ_REG_VRM_CENTER) begin
        reg_rdata_o <= resolution_mask_center_q;
      end else if (reg_addr_i == ARQ_REG_VRM_STATUS) begin
        reg_rdata_o <= {2'h0, heavy_q, reduced_q, bits_q};
      end else if (reg_addr_i == ARQ_REG_STAT_ROUTE) begin
        reg_rdata_o <= status_pin_routing_q;
      end else begin
        reg_rdata_o <= '0;
      end
    end
  end

  // decoded settings
  logic req_en;
  logic hb_active;
  logic hb_hp;
  logic [2:0] profile;
  logic [5:0] tw_eff;
  logic [6:0] band_lo;
  logic [6:0] band_ctr;
  logic vrm_en;
  logic vrm_cplx;
  logic vrm_wide;
  logic [3:0] mask_center_freq;
  arq_route_t route;

  assign req_en = requant_profile_select_q[ARQ_REQ_EN_BIT];
  assign hb_active = hb_ctrl_q[ARQ_HB_EN_BIT] && req_en;
  assign hb_hp = hb_ctrl_q[ARQ_HB_HP_BIT];
  assign profile = requant_profile_select_q[2:0];
  assign vrm_en = resolution_monitor_mode_q[ARQ_VRM_EN_BIT];
  assign vrm_cplx = resolution_monitor_mode_q[ARQ_VRM_CPLX_BIT];
  // real mode only allows the 25 percent band
  assign vrm_wide = vrm_cplx && resolution_monitor_mode_q[ARQ_VRM_WIDE_BIT];
  assign route = arq_route_t'(status_pin_routing_q[1:0]);

  always_comb begin
    // out-of-range tuning words are clamped to the last valid one
    if (profile == ARQ_PROFILE_WIDE) begin
      tw_eff = (requant_band_tuning_q[5:0] > ARQ_TW_MAX_WIDE) ? ARQ_TW_MAX_WIDE
             : requant_band_tuning_q[5:0];
    end else begin
      tw_eff = (requant_band_tuning_q[5:0] > ARQ_TW_MAX_NARROW) ? ARQ_TW_MAX_NARROW
             : requant_band_tuning_q[5:0];
    end
    band_lo = {1'b0, tw_eff};
    band_ctr = band_lo + ((profile == ARQ_PROFILE_WIDE) ? ARQ_CTR_OFS_WIDE
             : ARQ_CTR_OFS_NARROW);
  end

  always_comb begin
    mask_center_freq = resolution_mask_center_q[3:0];
    if (!vrm_cplx) begin
      if (mask_center_freq < ARQ_REAL_CTR_MIN) begin
        mask_center_freq = ARQ_REAL_CTR_MIN;
      end else if (mask_center_freq > ARQ_REAL_CTR_MAX) begin
        mask_center_freq = ARQ_REAL_CTR_MAX;
      end
    end
  end

  // whole pipeline advances only when the buffer can take a word
  logic adv;
  logic hb_valid;
  logic signed [DW-1:0] hb_data;

  arq_halfband #(.DW(DW)) u_hb (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .adv_i(adv),
    .valid_i(sample_valid_i),
    .data_i(sample_i),
    .active_i(hb_active),
    .hp_i(hb_hp),
    .valid_o(hb_valid),
    .data_o(hb_data)
  );

  // requantizer: 3 dB loss then error-feedback rounding to a coarse word
  logic signed [31:0] att;
  logic signed [31:0] shaped;
  logic signed [31:0] quant;
  logic signed [DW-1:0] req_sat;
  logic signed [DW-1:0] err_q;
  logic signed [DW-1:0] req_data_q;
  logic req_valid_q;
  localparam logic signed [31:0] MAXV = 32'sd2 ** (DW - 1) - 32'sd1;
  localparam logic signed [31:0] MINV = -(32'sd2 ** (DW - 1));

  always_comb begin
    att = (32'(hb_data) * 32'(ARQ_ATT_MUL) + (32'sd1 <<< (ARQ_ATT_SHIFT - 1)))
          >>> ARQ_ATT_SHIFT;
    // noise pushed away from the band: high side for low bands, low side otherwise
    shaped = (band_ctr < ARQ_QUARTER_FS) ? att - 32'(err_q) : att + 32'(err_q);
    quant = ((shaped + (32'sd1 <<< (DROP - 1))) >>> DROP) <<< DROP;
    if (quant > MAXV) begin
      req_sat = MAXV[DW-1:0] & ~DW'((1 << DROP) - 1);
    end else if (quant < MINV) begin
      req_sat = MINV[DW-1:0];
    end else begin
      req_sat = quant[DW-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_valid_q <= 1'b0;
      req_data_q <= '0;
      err_q <= '0;
    end else if (adv) begin
      req_valid_q <= hb_valid;
      if (hb_valid) begin
        if (req_en) begin
          req_data_q <= req_sat;
          err_q <= DW'(32'(req_sat) - shaped);
        end else begin
          req_data_q <= hb_data;
          err_q <= '0;
        end
      end
    end
  end

  // out-of-mask level: difference or sum of neighbours picks the far zone
  logic signed [DW-1:0] prev_q;
  logic signed [DW:0] pair;
  logic [DW:0] est_abs;
  logic [13:0] est;
  logic [13:0] peak_q;
  logic [13:0] peak_dec;
  logic low_ctr;

  assign low_ctr = (mask_center_freq < 4'h4) || (mask_center_freq > 4'hb);
  assign pair = low_ctr ? (DW+1)'(req_data_q) - (DW+1)'(prev_q)
              : (DW+1)'(req_data_q) + (DW+1)'(prev_q);
  assign est_abs = pair[DW] ? (DW+1)'(-pair) : pair;
  // the wide mask leaves less disallowed band, so weigh it down
  assign est = vrm_wide ? 14'(est_abs >> 2) : 14'(est_abs >> 1);
  assign peak_dec = peak_q - (peak_q >> ARQ_PEAK_DECAY);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= '0;
      peak_q <= '0;
    end else if (adv && req_valid_q) begin
      prev_q <= req_data_q;
      peak_q <= (est > peak_dec) ? est : peak_dec;
    end
  end

  logic [4:0] over;
  logic [3:0] bits_d;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_thr
      assign over[g] = peak_q > ARQ_VRM_THR[g];
    end
  endgenerate

  always_comb begin
    bits_d = ARQ_FULL_BITS;
    for (int i = 0; i < 5; i++) begin
      bits_d = bits_d - 4'(over[i]);
    end
    if (!vrm_en) begin
      bits_d = ARQ_FULL_BITS;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bits_q <= ARQ_FULL_BITS;
      reduced_q <= 1'b0;
      heavy_q <= 1'b0;
    end else begin
      bits_q <= bits_d;
      reduced_q <= (bits_q != ARQ_FULL_BITS);
      heavy_q <= (bits_q <= ARQ_HEAVY_BITS);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_pin_o <= 1'b0;
      overrange_pin_pair_o <= 1'b0;
    end else begin
      // only one flag is ever on the pins
      status_pin_o <= (route == ARQ_ROUTE_REDUCED_STATUS) && reduced_q;
      overrange_pin_pair_o <= ((route == ARQ_ROUTE_HEAVY_OVR) && heavy_q)
                           || ((route == ARQ_ROUTE_REDUCED_OVR) && reduced_q);
    end
  end

  // no gain change, only the lsbs below the kept width are cleared
  logic [DW-1:0] keep_mask;
  logic [DW-1:0] vrm_data;
  assign keep_mask = ~((DW'(1) << (DW'(ARQ_FULL_BITS) - DW'(bits_q))) - DW'(1));
  assign vrm_data = req_data_q & keep_mask;

  logic buf_ready;
  assign adv = buf_ready;
  assign sample_ready_o = buf_ready;

  arq_skid #(.W(DW), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(req_valid_q && adv),
    .in_data_i(vrm_data),
    .in_ready_o(buf_ready),
    .out_valid_o(out_valid_o),
    .out_data_o(out_data_o),
    .out_ready_i(out_ready_i)
  );

  property p_reduced;
    @(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> reduced_q == ($past(bits_q) != ARQ_FULL_BITS);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced flag wrong");

  property p_heavy;
    @(posedge clk_i) disable iff (!rst_b_i)
    (bits_q == 4'hd) |=> !heavy_q ##1 1'b1;
  endproperty
  a_heavy: assert property (p_heavy) else $error("heavy flag set at 13 bits");

  property p_bits_range;
    @(posedge clk_i) disable iff (!rst_b_i)
    bits_q >= ARQ_MIN_BITS && bits_q <= ARQ_FULL_BITS;
  endproperty
  a_bits_range: assert property (p_bits_range) else $error("resolution out of range");

  property p_quiet_full;
    @(posedge clk_i) disable iff (!rst_b_i)
    (peak_q <= ARQ_VRM_THR[0]) |=> bits_q == ARQ_FULL_BITS;
  endproperty
  a_quiet_full: assert property (p_quiet_full) else $error("bits dropped below threshold");

  property p_lsb_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
    (req_valid_q && adv && bits_q == ARQ_MIN_BITS) |-> vrm_data[4:0] == 5'h00;
  endproperty
  a_lsb_zero: assert property (p_lsb_zero) else $error("dropped lsbs not cleared");

  property p_route_one;
    @(posedge clk_i) disable iff (!rst_b_i)
    (route == ARQ_ROUTE_HEAVY_OVR) [*2] |-> !status_pin_o && overrange_pin_pair_o == $past(heavy_q);
  endproperty
  a_route_one: assert property (p_route_one) else $error("pin routing wrong");

  property p_hb_gate;
    @(posedge clk_i) disable iff (!rst_b_i)
    (adv && sample_valid_i && !req_en) |=> hb_valid;
  endproperty
  a_hb_gate: assert property (p_hb_gate) else $error("decimator active without requantizer");

  property p_tw_clamp;
    @(posedge clk_i) disable iff (!rst_b_i)
    (profile == ARQ_PROFILE_WIDE) |-> tw_eff <= ARQ_TW_MAX_WIDE && band_ctr == 7'(tw_eff) + 7'h1c;
  endproperty
  a_tw_clamp: assert property (p_tw_clamp) else $error("wide tuning out of range");

  property p_real_ctr;
    @(posedge clk_i) disable iff (!rst_b_i)
    !vrm_cplx |-> mask_center_freq inside {[4'h2:4'h6]} && !vrm_wide;
  endproperty
  a_real_ctr: assert property (p_real_ctr) else $error("real mode centre out of range");

  c_nine_bits: cover property (@(posedge clk_i) disable iff (!rst_b_i) bits_q == ARQ_MIN_BITS);
  c_status_pin: cover property (@(posedge clk_i) disable iff (!rst_b_i) status_pin_o);
endmodule : arq_top
`default_nettype wire

// ---- tb/arq_sink.sv ----
// downstream receiver model that collects output words and can stall
`timescale 1ns/1ps
`default_nettype none
module arq_sink
  import arq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [ARQ_DW-1:0] data_i,
  output logic ready_o
);
  logic [ARQ_DW-1:0] rx_q[$];
  // ready moves on the falling edge only, clear of the sampling edge
  always @(negedge clk_i or negedge rst_b_i) begin
    ready_o <= rst_b_i && !stall_i;
  end
  always @(posedge clk_i) begin
    if (rst_b_i && valid_i && ready_o) rx_q.push_back(data_i);
  end
endmodule : arq_sink
`default_nettype wire

// ---- tb/arq_top_bench.sv ----
// self-checking bench for the requantizer, decimator and resolution monitor
`timescale 1ns/1ps
`default_nettype none
module arq_top_bench;
  import arq_pkg::*;
  logic clk = 0, rst_b = 0, s_valid = 0, wr = 0, rd = 0, stall = 0;
  logic [13:0] sample = 0;
  logic [11:0] addr = 0;
  logic [7:0] wdata = 0;
  logic s_ready, o_valid, ready, st_pin, ov_pin;
  logic [13:0] o_data;
  logic [7:0] rdata;
  int n_fail = 0, total_checks = 0;
  initial forever #2 clk = ~clk;
  arq_top uut (.clk_i(clk), .rst_b_i(rst_b), .sample_i(sample), .sample_valid_i(s_valid),
    .sample_ready_o(s_ready), .out_data_o(o_data), .out_valid_o(o_valid), .out_ready_i(ready),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .status_pin_o(st_pin), .overrange_pin_pair_o(ov_pin));
  arq_sink sink (.clk_i(clk), .rst_b_i(rst_b), .stall_i(stall), .valid_i(o_valid),
    .data_i(o_data), .ready_o(ready));
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task conclude;
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task wr_reg(logic [11:0] a, logic [7:0] d);
    @(negedge clk); addr = a; wdata = d; wr = 1;
    @(negedge clk); wr = 0;
  endtask : wr_reg
  task rd_reg(logic [11:0] a, output logic [7:0] d);
    @(negedge clk); addr = a; rd = 1;
    @(negedge clk); rd = 0; d = rdata;
  endtask : rd_reg
  // holds the word until the edge that finds ready high
  task send(logic [13:0] v);
    int k;
    @(negedge clk); sample = v; s_valid = 1;
    for (k = 0; k < 400 && s_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk); s_valid = 0;
  endtask : send
  task t_regs;
    logic [7:0] d;
    rd_reg(ARQ_REG_REQ_PROFILE, d); check("profile reset", d, 8'h08);
    rd_reg(ARQ_REG_VRM_CENTER, d); check("centre reset", d, 8'h04);
    wr_reg(ARQ_REG_REQ_TUNE, 8'h3a); rd_reg(ARQ_REG_REQ_TUNE, d); check("tune", d, 8'h3a);
    wr_reg(ARQ_REG_HB_CTRL, 8'h80); rd_reg(ARQ_REG_HB_CTRL, d); check("hb ctrl", d, 8'h80);
    wr_reg(ARQ_REG_HB_CTRL, 8'h00);
    wr_reg(12'h123, 8'h55); rd_reg(12'h123, d); check("unmapped", d, 8'h00);
    check("pins idle", {st_pin, ov_pin}, 2'h0);
  endtask : t_regs
  // receiver stalls while six words are offered; none may be lost
  task t_stall;
    int i;
    wr_reg(ARQ_REG_REQ_PROFILE, 8'h00);
    sink.rx_q.delete(); stall = 1;
    fork
      for (i = 0; i < 6; i++) send(14'h0100 + 14'(i));
    join_none
    repeat (30) @(negedge clk);
    check("ready in stall", s_ready, 1'b0);
    stall = 0;
    wait fork;
    repeat (20) @(negedge clk);
    check("stall count", 16'(sink.rx_q.size()), 16'd6);
    for (i = 0; i < 6; i++) check("pass word", sink.rx_q[i], 14'h0100 + 14'(i));
  endtask : t_stall
  task t_hb;
    int i;
    logic signed [13:0] w;
    wr_reg(ARQ_REG_REQ_PROFILE, 8'h08); wr_reg(ARQ_REG_HB_CTRL, 8'h01);
    sink.rx_q.delete();
    for (i = 0; i < 8; i++) send(14'h0040);
    repeat (20) @(negedge clk);
    check("decim count", 16'(sink.rx_q.size()), 16'd4);
    // dc is rejected in high-pass and passed about 3 dB down in low-pass
    for (i = 0; i < 2; i++) begin
      wr_reg(ARQ_REG_HB_CTRL, (i == 0) ? 8'h81 : 8'h01);
      sink.rx_q.delete();
      repeat (20) send(14'h1000);
      repeat (20) @(negedge clk);
      w = sink.rx_q[sink.rx_q.size() - 1];
      if (i == 0) begin
        check("hp dc", 16'(w > -14'sd65 && w < 14'sd65), 16'h0001);
      end else begin
        check("lp dc", 16'(w > 14'sd2816 && w < 14'sd3072), 16'h0001);
      end
    end
    // decimator must stay out of the path while the requantizer is off
    wr_reg(ARQ_REG_REQ_PROFILE, 8'h00); sink.rx_q.delete();
    for (i = 0; i < 4; i++) send(14'h0040);
    repeat (20) @(negedge clk);
    check("hb gated", 16'(sink.rx_q.size()), 16'd4);
    wr_reg(ARQ_REG_HB_CTRL, 8'h00);
  endtask : t_hb
  // +/-8031 alternating at centre 0 sits far above -6 dBFS out of band
  // odd lsbs so that the cleared low bits are really seen
  task t_vrm;
    int i;
    logic [7:0] d;
    wr_reg(ARQ_REG_VRM_MODE, 8'h09); wr_reg(ARQ_REG_VRM_CENTER, 8'h00);
    sink.rx_q.delete();
    for (i = 0; i < 40; i++) send(i[0] ? 14'h1f5f : 14'h20a1);
    repeat (10) @(negedge clk);
    rd_reg(ARQ_REG_VRM_STATUS, d); check("nine bits", d, 8'h39);
    check("low bits", sink.rx_q[sink.rx_q.size() - 1][4:0], 5'h00);
    for (i = 0; i < 4; i++) begin
      wr_reg(ARQ_REG_STAT_ROUTE, 8'(i));
      repeat (3) @(negedge clk);
      check("status pin", st_pin, 1'(i == 2));
      check("ovr pin", ov_pin, 1'(i == 1 || i == 3));
    end
  endtask : t_vrm
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    repeat (2) @(negedge clk);
    t_regs();
    t_stall();
    t_hb();
    t_vrm();
    conclude();
  end
endmodule : arq_top_bench
`default_nettype wire
